// >>> motor_protection_supervisor.v
// motor protection supervisor with axi4-lite register access
// Overview of operation
// - responses: none, alarm, fault stop, fault coast
// - thermal load modeled from output current
// - first order thermal model, 1-200 min
// - zero speed cooling factor 5.0-150.0 percent
// - ambient temperature setting, default 40.0 C
// - stall: current over limit, freq below
// - stall current 0-5.2 A, default 3.7
// - stall response after stall time limit
// - underload only checked while running
// - underload threshold squared curve to fw point
// - below 5 Hz underload frozen, timer held
// - torque percent scaled from nominal currents
// - above fw point threshold is fw load
// - zero freq load default 10, reverts
// - underload response after time limit 2-600 s
`timescale 1ns/10ps
`include "prot_defs.vh"
module motor_protection_supervisor #(
  parameter W         = 16,
  parameter TICK_CYC  = `TICK_CYCLES
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] out_current,
  input  wire [W-1:0] out_freq,
  input  wire [W-1:0] out_torque,
  input  wire         running,
  input  wire [W-1:0] fw_point,
  input  wire         motor_nom_changed,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  output reg  [1:0]   s_axi_bresp,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  input  wire [7:0]   s_axi_araddr,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          alarm,
  output reg          fault_stop,
  output reg          fault_coast,
  output reg          irq
);
  // ********************
  // settings
  // ********************
  reg [31:0]  ctrl;
  reg [W-1:0] stall_current_limit;
  reg [W-1:0] stall_frequency_limit;
  reg [W-1:0] stall_time_limit;
  reg [W-1:0] underload_fw_load;
  reg [W-1:0] underload_zero_freq_load;
  reg [W-1:0] underload_time_limit;
  reg [W-1:0] thermal_time_constant;
  reg [W-1:0] zero_speed_cooling;
  reg [W-1:0] ambient_temp;
  reg [W-1:0] motor_nominal_current;
  reg [W-1:0] drive_rated_current;
  reg [2:0]   status;
  reg [2:0]   mask;
  wire [1:0]  thermal_response_select;
  wire [1:0]  stall_response_select;
  wire [1:0]  underload_response_select;

  assign thermal_response_select   = ctrl[`CTRL_THERM_LSB+1:`CTRL_THERM_LSB];
  assign stall_response_select     = ctrl[`CTRL_STALL_LSB+1:`CTRL_STALL_LSB];
  assign underload_response_select = ctrl[`CTRL_UL_LSB+1:`CTRL_UL_LSB];

  // limit a written value into its documented range
  function [W-1:0] clamp;
    input [31:0] v;
    input [W-1:0] lo;
    input [W-1:0] hi;
    begin
      if (v < {16'h0, lo})
        clamp = lo;
      else if (v > {16'h0, hi})
        clamp = hi;
      else
        clamp = v[W-1:0];
    end
  endfunction

  // ********************
  // 10 ms time base
  // ********************
  reg [31:0] tick_cnt;
  reg        tick;

  // divides the clock to one pulse per tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC - 1) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // ********************
  // thermal protection
  // ********************
  wire [W-1:0] therm_level;
  reg          therm_over;

  thermal_model #(.W(W)) u_thermal (
    .clk        (clk),
    .rst        (rst),
    .tick       (tick),
    .current    (out_current),
    .nominal    (motor_nominal_current),
    .freq       (out_freq),
    .fw_point   (fw_point),
    .cooling    (zero_speed_cooling),
    .ambient    (ambient_temp),
    .time_const (thermal_time_constant),
    .level      (therm_level)
  );

  // thermal stage over full load trips the protection
  always @(posedge clk or posedge rst) begin
    if (rst)
      therm_over <= 1'b0;
    else
      therm_over <= (therm_level > `THERM_TRIP);
  end

  // ********************
  // stall protection
  // ********************
  reg  stall_state;
  wire stall_expired;

  // current above limit while frequency stays below limit
  always @(posedge clk or posedge rst) begin
    if (rst)
      stall_state <= 1'b0;
    else
      stall_state <= (out_current > stall_current_limit) &&
                     (out_freq < stall_frequency_limit);
  end

  persist_timer #(.W(W)) u_stall_timer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .active  (stall_state),
    .hold    (1'b0),
    .limit   (stall_time_limit),
    .expired (stall_expired)
  );

  // ********************
  // underload protection
  // ********************
  reg  [W-1:0] torque_pct;
  reg  [W-1:0] ul_threshold;
  reg          ul_state;
  reg          ul_hold;
  wire         ul_expired;
  wire [31:0]  fsq;
  wire [31:0]  fwsq;
  wire [31:0]  span;
  wire [47:0]  curve;
  wire [31:0]  tq_scaled;

  // squared curve between zero frequency and the fw point
  assign fsq  = {16'h0, out_freq} * {16'h0, out_freq};
  assign fwsq = {16'h0, fw_point} * {16'h0, fw_point};
  assign span = (underload_fw_load > underload_zero_freq_load) ?
                {16'h0, underload_fw_load - underload_zero_freq_load} :
                {16'h0, underload_zero_freq_load - underload_fw_load};
  assign curve = (fwsq == 32'h0) ? 48'h0 :
                 ({16'h0, span} * {16'h0, fsq}) / {16'h0, fwsq};
  // torque rescaled to percent of motor nominal torque
  assign tq_scaled = (motor_nominal_current == {W{1'b0}}) ? 32'h0 :
     ({16'h0, out_torque} * {16'h0, drive_rated_current}) /
     {16'h0, motor_nominal_current};

  // builds threshold and underload state each cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_pct   <= {W{1'b0}};
      ul_threshold <= {W{1'b0}};
      ul_state     <= 1'b0;
      ul_hold      <= 1'b0;
    end else begin
      torque_pct <= (tq_scaled > 32'h0000_ffff) ? {W{1'b1}} :
                    tq_scaled[W-1:0];
      if (out_freq >= fw_point)
        ul_threshold <= underload_fw_load;
      else if (underload_fw_load >= underload_zero_freq_load)
        ul_threshold <= underload_zero_freq_load + curve[W-1:0];
      else
        ul_threshold <= underload_zero_freq_load - curve[W-1:0];
      ul_hold  <= running && (out_freq < `UL_MIN_FREQ);
      ul_state <= running && (out_freq >= `UL_MIN_FREQ) &&
                  (torque_pct < ul_threshold);
    end
  end

  persist_timer #(.W(W)) u_ul_timer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .active  (ul_state),
    .hold    (ul_hold),
    .limit   (underload_time_limit),
    .expired (ul_expired)
  );

  // ********************
  // response mapping
  // ********************
  wire [2:0] trip;
  wire [5:0] sel;
  reg  [2:0] next_resp;
  integer    i;

  assign trip = {ul_expired, stall_expired, therm_over};
  assign sel  = {underload_response_select, stall_response_select,
                 thermal_response_select};

  // merges each tripped protection into alarm, stop or coast
  always @* begin
    next_resp = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (trip[i]) begin
        case (sel[2*i +: 2])
          `RESP_ALARM:       next_resp[0] = 1'b1;
          `RESP_FAULT_STOP:  next_resp[1] = 1'b1;
          `RESP_FAULT_COAST: next_resp[2] = 1'b1;
          default:           next_resp = next_resp;
        endcase
      end
    end
  end

  // registered response and interrupt outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm       <= 1'b0;
      fault_stop  <= 1'b0;
      fault_coast <= 1'b0;
      irq         <= 1'b0;
    end else begin
      alarm       <= next_resp[0];
      fault_stop  <= next_resp[1];
      fault_coast <= next_resp[2];
      irq         <= |(status & mask);
    end
  end

  // ********************
  // axi4-lite slave
  // ********************
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [31:0] rd_val;
  reg        rd_ok;
  wire       do_write;
  wire [31:0] wval;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wval = {w_strb[3] ? w_data[31:24] : 8'h0,
                 w_strb[2] ? w_data[23:16] : 8'h0,
                 w_strb[1] ? w_data[15:8]  : 8'h0,
                 w_strb[0] ? w_data[7:0]   : 8'h0};

  // accepts address and data in either order, answers once both held
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `REG_THERM_LEVEL) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes and nominal change revert
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl                     <= `CTRL_RESET;
      stall_current_limit      <= `STALL_CUR_DEF;
      stall_frequency_limit    <= `STALL_FREQ_DEF;
      stall_time_limit         <= `STALL_TIME_DEF;
      underload_fw_load        <= `UL_FW_DEF;
      underload_zero_freq_load <= `UL_ZERO_DEF;
      underload_time_limit     <= `UL_TIME_DEF;
      thermal_time_constant    <= `THERM_TC_DEF;
      zero_speed_cooling       <= `COOL_DEF;
      ambient_temp             <= `AMBIENT_DEF;
      motor_nominal_current    <= `PCT_FULL;
      drive_rated_current      <= `PCT_FULL;
      mask                     <= 3'h0;
    end else begin
      if (do_write) begin
        case (aw_addr)
          `REG_CTRL:       ctrl <= {26'h0, wval[5:0]};
          `REG_STALL_CUR:  stall_current_limit <=
                             clamp(wval, 16'h0, `STALL_CUR_MAX);
          `REG_STALL_FREQ: stall_frequency_limit <= wval[W-1:0];
          `REG_STALL_TIME: stall_time_limit <=
                             clamp(wval, 16'h0, `STALL_TIME_MAX);
          `REG_UL_FW:      underload_fw_load <=
                             clamp(wval, 16'h0, `UL_FW_MAX);
          `REG_UL_ZERO:    underload_zero_freq_load <= wval[W-1:0];
          `REG_UL_TIME:    underload_time_limit <=
                             clamp(wval, `UL_TIME_MIN, `UL_TIME_MAX);
          `REG_THERM_TC:   thermal_time_constant <=
                             clamp(wval, `THERM_TC_MIN, `THERM_TC_MAX);
          `REG_THERM_COOL: zero_speed_cooling <=
                             clamp(wval, `COOL_MIN, `COOL_MAX);
          `REG_AMBIENT:    ambient_temp <= wval[W-1:0];
          `REG_NOMINAL: begin
            motor_nominal_current <= wval[W-1:0];
            drive_rated_current   <= wval[31:16];
          end
          `REG_MASK:       mask <= wval[2:0];
          default:         ctrl <= ctrl;
        endcase
      end
      if (motor_nom_changed)
        underload_zero_freq_load <= `UL_ZERO_DEF;
    end
  end

  // events set status bits; a set in the clear cycle wins
  always @(posedge clk or posedge rst) begin
    if (rst)
      status <= 3'h0;
    else if (do_write && aw_addr == `REG_STATUS)
      status <= (status & ~wval[2:0]) | trip;
    else
      status <= status | trip;
  end

  // read mux
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (s_axi_araddr)
      `REG_CTRL:        rd_val = ctrl;
      `REG_STALL_CUR:   rd_val = {16'h0, stall_current_limit};
      `REG_STALL_FREQ:  rd_val = {16'h0, stall_frequency_limit};
      `REG_STALL_TIME:  rd_val = {16'h0, stall_time_limit};
      `REG_UL_FW:       rd_val = {16'h0, underload_fw_load};
      `REG_UL_ZERO:     rd_val = {16'h0, underload_zero_freq_load};
      `REG_UL_TIME:     rd_val = {16'h0, underload_time_limit};
      `REG_THERM_TC:    rd_val = {16'h0, thermal_time_constant};
      `REG_THERM_COOL:  rd_val = {16'h0, zero_speed_cooling};
      `REG_AMBIENT:     rd_val = {16'h0, ambient_temp};
      `REG_NOMINAL:     rd_val = {drive_rated_current, motor_nominal_current};
      `REG_STATUS:      rd_val = {29'h0, status};
      `REG_MASK:        rd_val = {29'h0, mask};
      `REG_STATE:       rd_val = {25'h0, ul_state, stall_state, therm_over,
                                  fault_coast, fault_stop, alarm};
      `REG_THERM_LEVEL: rd_val = {16'h0, therm_level};
      default:          rd_ok  = 1'b0;
    endcase
  end

  // read channel: address taken, data one cycle later
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> prot_defs.vh
// constants for the motor protection supervisor
`ifndef PROT_DEFS_VH
`define PROT_DEFS_VH
// ********************
// register offsets
// ********************
`define REG_CTRL        8'h00
`define REG_STALL_CUR   8'h04
`define REG_STALL_FREQ  8'h08
`define REG_STALL_TIME  8'h0c
`define REG_UL_FW       8'h10
`define REG_UL_ZERO     8'h14
`define REG_UL_TIME     8'h18
`define REG_THERM_TC    8'h1c
`define REG_THERM_COOL  8'h20
`define REG_AMBIENT     8'h24
`define REG_NOMINAL     8'h28
`define REG_STATUS      8'h2c
`define REG_MASK        8'h30
`define REG_STATE       8'h34
`define REG_THERM_LEVEL 8'h38
// ********************
// control fields
// ********************
`define CTRL_THERM_LSB  0
`define CTRL_STALL_LSB  2
`define CTRL_UL_LSB     4
`define CTRL_RESET      32'h0000_0002
// ********************
// response codes
// ********************
`define RESP_NONE       2'h0
`define RESP_ALARM      2'h1
`define RESP_FAULT_STOP 2'h2
`define RESP_FAULT_COAST 2'h3
// ********************
// reset values; current in 10 mA, freq in 10 mHz, time in 10 ms,
// percent in 0.1 %, temperature in 0.1 C, time constant in minutes
// ********************
`define STALL_CUR_DEF   16'h0172
`define STALL_CUR_MAX   16'h0208
`define STALL_FREQ_DEF  16'h09c4
`define STALL_TIME_DEF  16'h05dc
`define STALL_TIME_MAX  16'h2ee0
`define UL_FW_DEF       16'h01f4
`define UL_FW_MAX       16'h05dc
`define UL_ZERO_DEF     16'h0064
`define UL_TIME_DEF     16'h07d0
`define UL_TIME_MIN     16'h00c8
`define UL_TIME_MAX     16'hea60
`define UL_MIN_FREQ     16'h01f4
`define THERM_TC_DEF    16'h002d
`define THERM_TC_MIN    16'h0001
`define THERM_TC_MAX    16'h00c8
`define COOL_DEF        16'h0064
`define COOL_MIN        16'h0032
`define COOL_MAX        16'h05dc
`define AMBIENT_DEF     16'h0190
`define FW_POINT_DEF    16'h1388
`define PCT_FULL        16'h03e8
`define THERM_TRIP      16'h03e8
// ********************
// timing: 10 ms tick at 200 MHz, ticks per minute
// ********************
`define CLK_HZ          200000000
`define TICK_MS         10
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_MIN   6000
`endif

// >>> persist_timer.v
// timer that measures how long a condition has persisted
`timescale 1ns/10ps
module persist_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         tick,
  input  wire         active,
  input  wire         hold,
  input  wire [W-1:0] limit,
  output reg          expired
);
  reg [W-1:0] count;

  // counts ticks while active, holds while frozen, clears when state ends
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count   <= {W{1'b0}};
      expired <= 1'b0;
    end else if (hold) begin
      count <= count;
    end else if (!active) begin
      count   <= {W{1'b0}};
      expired <= 1'b0;
    end else begin
      if (tick && count != {W{1'b1}})
        count <= count + {{(W-1){1'b0}}, 1'b1};
      expired <= (count > limit);
    end
  end
endmodule

// >>> thermal_model.v
// first order motor heating model driven by output current
`timescale 1ns/10ps
`include "prot_defs.vh"
module thermal_model #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         tick,
  input  wire [W-1:0] current,
  input  wire [W-1:0] nominal,
  input  wire [W-1:0] freq,
  input  wire [W-1:0] fw_point,
  input  wire [W-1:0] cooling,
  input  wire [W-1:0] ambient,
  input  wire [W-1:0] time_const,
  output reg  [W-1:0] level
);
  reg  [W+15:0] acc;
  reg  [31:0]   div;
  wire [31:0]   ratio;
  wire [31:0]   cool_eff;
  wire [47:0]   target;
  wire [47:0]   amb_adj;
  wire [47:0]   scaled;
  wire [W+15:0] goal;
  wire [W+15:0] step_down;

  // load ratio in 0.1 % of nominal current
  assign ratio = (nominal == {W{1'b0}}) ? 32'h0 :
                 ({16'h0, current} * `PCT_FULL) / {16'h0, nominal};
  // cooling rises from the zero speed factor to full at the fw point
  assign cool_eff = (freq >= fw_point) ? {16'h0, `PCT_FULL} :
     {16'h0, cooling} + ((({16'h0, `PCT_FULL} - {16'h0, cooling}) *
     {16'h0, freq}) / {16'h0, fw_point});
  // steady state is load squared over cooling, scaled by ambient
  assign target = (cool_eff == 32'h0) ? 48'h0 :
     ({16'h0, ratio} * {16'h0, ratio}) / {16'h0, cool_eff};
  assign amb_adj = {32'h0, ambient} + `PCT_FULL - `AMBIENT_DEF;
  assign scaled = {32'h0, target[15:0]} * amb_adj / `PCT_FULL;
  assign goal = (|target[47:16] || |scaled[47:16]) ? {16'hffff, 16'h0} :
     {scaled[15:0], 16'h0};

  // one tick of the exponential: move 1/(tau*6000) of the gap
  assign step_down = (goal > acc) ? (goal - acc) : (acc - goal);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc   <= {(W+16){1'b0}};
      level <= {W{1'b0}};
      div   <= 32'h0;
    end else begin
      div <= {16'h0, time_const} * `TICKS_PER_MIN;
      if (tick && div != 32'h0) begin
        if (goal > acc)
          acc <= acc + step_down / div;
        else
          acc <= acc - step_down / div;
      end
      level <= acc[W+15:16];
    end
  end
endmodule

// >>> mps_assertions.sv
// port checker for the motor protection supervisor
`timescale 1ns/10ps
module mps_checker (
  input wire        clk,
  input wire        rst,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        alarm,
  input wire        fault_stop,
  input wire        fault_coast,
  input wire        irq
);
  // all checks run on the system clock, muted in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  quiet_after_reset_a: assert property ($fell(rst) |->
    !(alarm | fault_stop | fault_coast | irq))
    else $error("output high right after reset");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready longer than one cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  write_answer_a: assert property (s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data late");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h38 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind motor_protection_supervisor mps_checker u_mps_checker (
  .clk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .alarm, .fault_stop,
  .fault_coast, .irq
);

// >>> motor_model.sv
// behavioural motor and power stage seen by the supervisor
`timescale 1ns/10ps
module motor_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] cur_cmd,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] trq_cmd,
  input  wire logic        run_cmd,
  input  wire logic        fault_stop,
  input  wire logic        fault_coast,
  output logic      [15:0] out_current,
  output logic      [15:0] out_freq,
  output logic      [15:0] out_torque,
  output logic             running
);
  logic stopped;

  // a fault halts the motor until the run command is withdrawn;
  // measured values follow the load one cycle late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stopped <= 1'b0;
      running <= 1'b0;
      out_current <= 16'h0;
      out_freq <= 16'h0;
      out_torque <= 16'h0;
    end else begin
      stopped <= run_cmd & (stopped | fault_stop | fault_coast);
      running <= run_cmd & ~stopped;
      out_current <= stopped ? 16'h0 : cur_cmd;
      out_freq <= stopped ? 16'h0 : freq_cmd;
      out_torque <= stopped ? 16'h0 : trq_cmd;
    end
  end
endmodule

// >>> tb_top.sv
// self-checking bench for the motor protection supervisor
`timescale 1ns/10ps
`include "prot_defs.vh"
module tb_top;
  localparam int T = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run_cmd = 1'b0, nom_chg = 1'b0, f_coast, irq;
  logic [15:0] cur_cmd = 16'h0, freq_cmd = 16'h0, trq_cmd = 16'h0;
  logic [15:0] cur, freq, trq, f;
  logic        running, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, alarm, f_stop;
  logic [1:0]  bresp, rresp, br, rr;
  int          mismatches = 0, n_tests = 0;
  logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                         8'h18, 8'h24};
  logic [31:0] rv[8] = '{`CTRL_RESET, `STALL_CUR_DEF, `STALL_FREQ_DEF,
                         `STALL_TIME_DEF, `UL_FW_DEF, `UL_ZERO_DEF,
                         `UL_TIME_DEF, `AMBIENT_DEF};

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  motor_protection_supervisor #(.TICK_CYC(T)) u_motor_protection_supervisor (
    .clk(clk), .rst(rst), .out_current(cur), .out_freq(freq),
    .out_torque(trq), .running(running), .fw_point(`FW_POINT_DEF),
    .motor_nom_changed(nom_chg), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .alarm(alarm), .fault_stop(f_stop),
    .fault_coast(f_coast), .irq(irq));

  motor_model u_motor_model (
    .clk(clk), .rst(rst), .cur_cmd(cur_cmd), .freq_cmd(freq_cmd),
    .trq_cmd(trq_cmd), .run_cmd(run_cmd), .fault_stop(f_stop),
    .fault_coast(f_coast), .out_current(cur), .out_freq(freq),
    .out_torque(trq), .running(running));

  // ********************
  // checking and bus tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input [7:0] a, input [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (bvalid) break;
      awv <= awv & ~awready;
      wv <= wv & ~wready;
    end
    br = bresp;
    if (k == 40) chk("write wait", 1, 0);
    if (k == 40) close_out;
  endtask

  task automatic rdr(input [7:0] a);
    int k;
    araddr <= a;
    arv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (rvalid) break;
      arv <= arv & ~arready;
    end
    rd = rdata;
    rr = rresp;
    if (k == 40) chk("read wait", 1, 0);
    if (k == 40) close_out;
  endtask

  task automatic drive(input [15:0] c, fr, q, input r);
    cur_cmd <= c;
    freq_cmd <= fr;
    trq_cmd <= q;
    run_cmd <= r;
  endtask

  // one-hot {coast, stop, alarm} for a response code
  function automatic [2:0] resp_exp(input [1:0] code);
    resp_exp = (code == 2'h0) ? 3'h0 : 3'h1 << (code - 2'h1);
  endfunction

  // minimum torque on the squared underload curve
  function automatic int thr(input int fr);
    longint s;
    s = longint'(`UL_FW_DEF) - `UL_ZERO_DEF;
    if (fr >= `FW_POINT_DEF) return `UL_FW_DEF;
    return `UL_ZERO_DEF + int'(s * fr * fr / (5000 * 5000));
  endfunction

  // wait for a response, then remove the condition
  task automatic trip(input [1:0] code, input int lim);
    int n;
    logic [2:0] s;
    s = 3'h0;
    for (n = 0; n < (lim + 4) * T && s == 3'h0; n++) begin
      @(posedge clk);
      s = {f_coast, f_stop, alarm};
    end
    chk("response", resp_exp(code), s);
    if (code != 2'h0) chk("delay", 1, 32'(n > (lim - 1) * T));
    drive(0, 0, 0, 0);
    repeat (6) @(posedge clk);
    chk("clear", 0, {f_coast, f_stop, alarm});
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'h5bef1658));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rdr(ra[i]);
      chk("default", rv[i], rd);
    end
    rdr(8'h3c);
    chk("unmapped rresp", 2, rr);
    wr(8'h40, 32'h1);
    chk("unmapped bresp", 2, br);
    wr(`REG_UL_ZERO, 32'h12c);
    nom_chg <= 1'b1;
    @(posedge clk);
    nom_chg <= 1'b0;
    rdr(`REG_UL_ZERO);
    chk("zero load revert", `UL_ZERO_DEF, rd);
    wr(`REG_STALL_TIME, 32'h64);
    wr(`REG_MASK, 32'h2);
    // each stall code, after an interrupted half-length stall
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, c << `CTRL_STALL_LSB);
      drive(16'h200, 16'h3e8, 0, 1);
      repeat (50 * T) @(posedge clk);
      drive(0, 0, 0, 1);
      repeat (5) @(posedge clk);
      drive(16'h173 + $urandom % 16'h95, $urandom % 16'h9c4, 0, 1);
      trip(c, 100);
    end
    chk("irq raised", 1, irq);
    rdr(`REG_STATUS);
    chk("status stall", 2, rd & 32'h2);
    wr(`REG_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    wr(`REG_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 1, irq);
    wr(`REG_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    wr(`REG_CTRL, 1 << `CTRL_STALL_LSB);
    drive(16'h172, 16'h3e8, 0, 1);
    trip(0, 100);
    drive(16'h200, 16'h9c4, 0, 1);
    trip(0, 100);
    wr(`REG_UL_TIME, 32'hc8);
    // each underload code above the field weakening point
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, c << `CTRL_UL_LSB);
      f = 16'h1388 + $urandom % 16'hfa0;
      drive(0, f, 16'($urandom % thr(f)), 1);
      trip(c, 200);
    end
    wr(`REG_CTRL, 1 << `CTRL_UL_LSB);
    drive(0, 16'h9c4, 16'(thr(2500) - 1), 1);
    trip(1, 200);
    drive(0, 16'h9c4, 16'(thr(2500)), 1);
    trip(0, 200);
    drive(0, 16'h1770, 16'h64, 0);
    trip(0, 200);
    drive(0, 16'h1770, 16'h64, 1);
    repeat (100 * T) @(posedge clk);
    drive(0, 16'h1f3, 16'h64, 1);
    repeat (300 * T) @(posedge clk);
    chk("held", 0, {f_coast, f_stop, alarm});
    drive(0, 16'h1770, 16'h64, 1);
    trip(1, 100);
    close_out;
  end
endmodule
